// ===== verilog/data_space_addressing.sv
// data space read/write addressing, paging, lanes and traps
`timescale 1ns/1ps
`default_nettype none
module data_space_addressing (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic issue_i,
  input wire logic rd_en_i,
  input wire logic [2:0] rd_mode_i,
  input wire logic [15:0] rd_ptr_i,
  input wire logic [15:0] rd_direct_i,
  input wire logic wr_en_i,
  input wire logic [2:0] wr_mode_i,
  input wire logic [15:0] wr_ptr_i,
  input wire logic [15:0] wr_direct_i,
  input wire logic [15:0] wr_data_i,
  input wire logic byte_i,
  input wire logic [1:0] ext_i,
  input wire logic [15:0] dest_old_i,
  input wire logic page_wr_rd_i,
  input wire logic page_wr_wr_i,
  input wire logic [9:0] page_wdata_i,
  input wire logic [15:0] sfr_rdata_i,
  input wire logic sfr_hit_i,
  output logic [15:0] rd_value_o,
  output logic [15:0] rd_ptr_next_o,
  output logic [15:0] wr_ptr_next_o,
  output logic [23:0] rd_ext_addr_o,
  output logic [23:0] wr_ext_addr_o,
  output logic [9:0] read_page_select_o,
  output logic [9:0] write_page_select_o,
  output logic [15:0] sfr_addr_o,
  output logic [15:0] sfr_wdata_o,
  output logic [1:0] sfr_wstrb_o,
  output logic done_o,
  output logic addr_err_trap_o
);
  logic [9:0] read_page_select_q;
  logic [9:0] write_page_select_q;
  logic [9:0] rd_page_next;
  logic [9:0] wr_page_next;
  logic [15:0] rd_ea;
  logic [15:0] wr_ea;
  logic [15:0] rd_ptr_nx;
  logic [15:0] wr_ptr_nx;
  logic [7:0] ram_lo_q [data_space_pkg::RAM_WORDS];
  logic [7:0] ram_hi_q [data_space_pkg::RAM_WORDS];
  logic [15:0] rd_word;
  logic [15:0] lane_value;
  logic rd_paged;
  logic wr_paged;
  logic rd_mis;
  logic wr_mis;
  logic rd_pg_err;
  logic wr_pg_err;
  logic wr_ps_err;
  logic any_err;
  logic wr_go;
  logic [1:0] strobe;
  logic [15:0] rd_value_q;
  logic [15:0] rd_ptr_next_q;
  logic [15:0] wr_ptr_next_q;
  logic [23:0] rd_ext_q;
  logic [23:0] wr_ext_q;
  logic done_q;
  logic trap_q;
  data_space_pkg::acc_state_e state_q;

  function automatic logic is_ram(input logic [15:0] a);
    is_ram = (a > data_space_pkg::SFR_LAST) &&
             (a <= data_space_pkg::IMPL_LAST);
  endfunction

  function automatic logic [12:0] ram_idx(input logic [15:0] a);
    logic [15:0] off;
    off = a - data_space_pkg::SFR_LAST - 16'h0001;
    ram_idx = off[13:1]; // RL2
  endfunction

  function automatic logic is_pre(input logic [2:0] m);
    is_pre = (m == data_space_pkg::MODE_PRE_INC) ||
             (m == data_space_pkg::MODE_PRE_DEC);
  endfunction

  function automatic logic [23:0] ext_addr(input logic [15:0] ea,
                                           input logic [9:0] pg);
    // page joined only when bit 15 set
    if (ea[15]) begin
      ext_addr = {pg[8:0], ea[14:0]}; // RL3
    end else begin
      ext_addr = {8'h00, ea}; // RL24
    end
  endfunction

  // separate generators, both evaluated every instruction
  address_gen_unit rd_addr_gen ( // RL1
    .mode_i(rd_mode_i),
    .byte_i(byte_i),
    .ptr_i(rd_ptr_i),
    .direct_i(rd_direct_i),
    .page_i(read_page_select_q),
    .ea_o(rd_ea),
    .ptr_next_o(rd_ptr_nx),
    .page_next_o(rd_page_next)
  );

  address_gen_unit wr_addr_gen ( // RL1 RL16
    .mode_i(wr_mode_i),
    .byte_i(byte_i),
    .ptr_i(wr_ptr_i),
    .direct_i(wr_direct_i),
    .page_i(write_page_select_q),
    .ea_o(wr_ea),
    .ptr_next_o(wr_ptr_nx),
    .page_next_o(wr_page_next)
  );

  always_comb begin
    rd_paged = rd_ea[15];
    wr_paged = wr_ea[15];
    rd_mis = rd_en_i && !byte_i && rd_ea[0]; // RL9
    wr_mis = wr_en_i && !byte_i && wr_ea[0]; // RL9
    rd_pg_err = rd_en_i && rd_paged &&
                (read_page_select_q == data_space_pkg::PAGE_ZERO); // RL21
    wr_pg_err = wr_en_i && wr_paged &&
                (write_page_select_q == data_space_pkg::PAGE_ZERO); // RL21
    wr_ps_err = wr_en_i && wr_paged &&
                write_page_select_q[9]; // RL22
    any_err = rd_mis || wr_mis || rd_pg_err || wr_pg_err || wr_ps_err;
    wr_go = wr_en_i && !wr_mis && !wr_pg_err && !wr_ps_err; // RL10
    if (byte_i) begin
      strobe = wr_ea[0] ? 2'b10 : 2'b01; // RL8
    end else begin
      strobe = 2'b11;
    end
  end

  // base space read: sfr, ram, or zero
  always_comb begin
    if (rd_paged) begin
      rd_word = 16'h0000;
    end else if (rd_ea <= data_space_pkg::SFR_LAST) begin
      rd_word = sfr_hit_i ? sfr_rdata_i : 16'h0000; // RL13
    end else if (is_ram(rd_ea)) begin
      rd_word = {ram_hi_q[ram_idx(rd_ea)], ram_lo_q[ram_idx(rd_ea)]};
    end else begin
      rd_word = 16'h0000; // RL4
    end
  end

  data_lane_unit lanes (
    .word_i(rd_word),
    .addr0_i(rd_ea[0]),
    .byte_i(byte_i),
    .ext_i(ext_i),
    .dest_old_i(dest_old_i),
    .value_o(lane_value)
  );

  // sfr side write port
  always_comb begin
    sfr_addr_o = (wr_en_i) ? {wr_ea[15:1], 1'b0} : {rd_ea[15:1], 1'b0};
    sfr_wdata_o = byte_i ? {wr_data_i[7:0], wr_data_i[7:0]} : wr_data_i;
    sfr_wstrb_o = 2'b00;
    if (issue_i && ce_i && wr_go && !wr_paged &&
        wr_ea <= data_space_pkg::SFR_LAST) begin
      sfr_wstrb_o = strobe; // RL8
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && issue_i && wr_go && !wr_paged && is_ram(wr_ea)) begin
      if (strobe[0]) begin
        ram_lo_q[ram_idx(wr_ea)] <= wr_data_i[7:0]; // RL5 RL8
      end
      if (strobe[1]) begin
        ram_hi_q[ram_idx(wr_ea)] <=
          byte_i ? wr_data_i[7:0] : wr_data_i[15:8]; // RL5 RL8
      end
    end
  end

  // page registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      read_page_select_q <= data_space_pkg::PAGE_RST;
      write_page_select_q <= data_space_pkg::PAGE_RST;
    end else if (ce_i) begin
      if (page_wr_rd_i) begin
        read_page_select_q <= page_wdata_i;
      end else if (issue_i && rd_en_i) begin
        read_page_select_q <= rd_page_next; // RL18 RL19
      end
      if (page_wr_wr_i) begin
        write_page_select_q <= page_wdata_i;
      end else if (issue_i && wr_en_i) begin
        write_page_select_q <= wr_page_next; // RL18 RL19
      end
    end
  end

  // results of the instruction
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_value_q <= 16'h0000;
      rd_ptr_next_q <= 16'h0000;
      wr_ptr_next_q <= 16'h0000;
      rd_ext_q <= 24'h000000;
      wr_ext_q <= 24'h000000;
      done_q <= 1'b0;
    end else if (ce_i) begin
      done_q <= issue_i;
      if (issue_i) begin
        rd_value_q <= rd_en_i ? lane_value : dest_old_i; // RL10
        rd_ptr_next_q <= rd_ptr_nx; // RL6
        wr_ptr_next_q <= wr_ptr_nx; // RL6
        rd_ext_q <= ext_addr(rd_ea, is_pre(rd_mode_i) ?
          rd_page_next : read_page_select_q); // RL3 RL18
        wr_ext_q <= ext_addr(wr_ea, is_pre(wr_mode_i) ?
          wr_page_next : write_page_select_q); // RL3 RL18
      end
    end
  end

  // trap follows completion of the faulting instruction
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= data_space_pkg::ACC_IDLE;
      trap_q <= 1'b0;
    end else if (ce_i) begin
      unique case (state_q)
        data_space_pkg::ACC_IDLE: begin
          trap_q <= 1'b0;
          if (issue_i && any_err) begin
            state_q <= data_space_pkg::ACC_TRAP; // RL10
          end
        end
        data_space_pkg::ACC_TRAP: begin
          trap_q <= 1'b1; // RL9 RL10
          // back-to-back fault keeps the trap pending
          if (!(issue_i && any_err)) begin
            state_q <= data_space_pkg::ACC_IDLE;
          end
        end
        default: begin
          state_q <= data_space_pkg::ACC_IDLE;
          trap_q <= 1'b0;
        end
      endcase
    end
  end

  assign rd_value_o = rd_value_q;
  assign rd_ptr_next_o = rd_ptr_next_q;
  assign wr_ptr_next_o = wr_ptr_next_q;
  assign rd_ext_addr_o = rd_ext_q;
  assign wr_ext_addr_o = wr_ext_q;
  assign read_page_select_o = read_page_select_q;
  assign write_page_select_o = write_page_select_q;
  assign done_o = done_q;
  assign addr_err_trap_o = trap_q;
endmodule
`default_nettype wire

// ===== common/data_space_pkg.sv
// constants and types for data space address generation
// How it works
// RL1 - read and write addresses come from separate generator paths in one cycle
// RL2 - effective addresses are 16 bits, byte granular, 64 Kbyte base range
// RL3 - base address joins read or write page for a 16 Mbyte extended space
// RL4 - reads outside implemented SFR and RAM area return zero
// RL5 - low byte sits at even address, high byte at odd address
// RL6 - pre/post modify steps one for bytes, two for words
// RL7 - byte read fetches the word, picks by bit 0, lands on low lane
// RL8 - shared word decode, separate lane write strobes for byte writes
// RL9 - word access to odd address raises address error trap
// RL10 - misaligned read completes, misaligned write suppressed, trap follows
// RL11 - byte load into working register keeps its high byte
// RL12 - sign extend widens signed byte; zero extend clears high byte
// RL13 - lowest 4 Kbytes hold control registers; unused ones read zero
// RL14 - direct instructions reach the 8 Kbyte near region via 13-bit field
// RL15 - moves reach all data space by 16-bit field or register pointer
// RL16 - one instruction may read one page and write another
// RL17 - paged pre/post modified access crossing a page clears bit 15
// RL18 - overflow increments page and sets bit 15
// RL19 - underflow decrements page and sets bit 15
// RL20 - offset, modulo, bit-reversed modes wrap in page, page unchanged
// RL21 - paged access with page zero raises address error trap
// RL22 - program space is read only; write page into it traps
// RL23 - boundary pages keep page, clear bit 15, fall to base space
// RL24 - bit 15 clear accesses base space and ignores page
package data_space_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned PAGE_W = 10;
  localparam int unsigned EXT_W = 24;
  localparam int unsigned NEAR_W = 13;
  localparam logic [15:0] SFR_LAST = 16'h0fff;
  localparam logic [15:0] NEAR_LAST = 16'h1fff;
  localparam logic [15:0] IMPL_LAST = 16'h4fff;
  localparam int unsigned RAM_WORDS = 8192;
  localparam int unsigned RAM_IDX_W = 13;
  localparam logic [9:0] PAGE_RST = 10'h001;
  localparam logic [9:0] PAGE_ZERO = 10'h000;
  localparam logic [9:0] EXT_LAST = 10'h1ff;
  localparam logic [9:0] PROG_FIRST = 10'h200;
  localparam logic [9:0] PROG_LO_LAST = 10'h2ff;
  localparam logic [9:0] PROG_HI_FIRST = 10'h300;
  localparam logic [9:0] PROG_LAST = 10'h3ff;
  localparam logic [9:0] EXT_FIRST = 10'h001;
  // addressing modes
  typedef enum logic [2:0] {
    MODE_DIRECT = 3'h0,
    MODE_NEAR = 3'h1,
    MODE_IND = 3'h2,
    MODE_POST_INC = 3'h3,
    MODE_POST_DEC = 3'h4,
    MODE_PRE_INC = 3'h5,
    MODE_PRE_DEC = 3'h6,
    MODE_WRAP = 3'h7
  } mode_e;
  typedef enum logic [1:0] {
    EXT_NONE = 2'h0,
    EXT_SIGN = 2'h1,
    EXT_ZERO = 2'h2
  } ext_e;
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b01,
    ACC_TRAP = 2'b10
  } acc_state_e;
endpackage

// ===== verilog/address_gen_unit.sv
// one address generator: effective address and page update
`timescale 1ns/1ps
`default_nettype none
module address_gen_unit (
  input wire logic [2:0] mode_i,
  input wire logic byte_i,
  input wire logic [15:0] ptr_i,
  input wire logic [15:0] direct_i,
  input wire logic [9:0] page_i,
  output logic [15:0] ea_o,
  output logic [15:0] ptr_next_o,
  output logic [9:0] page_next_o
);
  logic [15:0] step;
  logic [16:0] inc_sum;
  logic [16:0] dec_sum;
  logic [15:0] raw_ea;
  logic paged;
  logic cross_up;
  logic cross_dn;
  logic boundary;
  logic pre;
  always_comb begin
    step = byte_i ? 16'h0001 : 16'h0002; // RL6
    inc_sum = {1'b0, ptr_i} + {1'b0, step};
    dec_sum = {1'b0, ptr_i} - {1'b0, step};
    paged = ptr_i[15] && (page_i != data_space_pkg::PAGE_ZERO);
    ptr_next_o = ptr_i;
    page_next_o = page_i;
    raw_ea = ptr_i;
    cross_up = 1'b0;
    cross_dn = 1'b0;
    pre = 1'b0;
    unique case (data_space_pkg::mode_e'(mode_i))
      data_space_pkg::MODE_DIRECT: raw_ea = direct_i; // RL15
      data_space_pkg::MODE_NEAR:
        raw_ea = {3'h0, direct_i[data_space_pkg::NEAR_W-1:0]}; // RL14
      data_space_pkg::MODE_IND: raw_ea = ptr_i; // RL15
      data_space_pkg::MODE_POST_INC: begin
        ptr_next_o = inc_sum[15:0];
        cross_up = paged && !inc_sum[15]; // RL17
      end
      data_space_pkg::MODE_POST_DEC: begin
        ptr_next_o = dec_sum[15:0];
        cross_dn = paged && !dec_sum[15]; // RL17
      end
      data_space_pkg::MODE_PRE_INC: begin
        ptr_next_o = inc_sum[15:0];
        raw_ea = inc_sum[15:0];
        pre = 1'b1;
        cross_up = paged && !inc_sum[15]; // RL17
      end
      data_space_pkg::MODE_PRE_DEC: begin
        ptr_next_o = dec_sum[15:0];
        raw_ea = dec_sum[15:0];
        pre = 1'b1;
        cross_dn = paged && !dec_sum[15]; // RL17
      end
      data_space_pkg::MODE_WRAP: begin
        // offset, modulo, bit-reversed: stay in page
        raw_ea = direct_i;
        if (ptr_i[15]) begin
          raw_ea[15] = 1'b1; // RL20
        end
      end
      default: raw_ea = ptr_i;
    endcase
    boundary = (cross_up && (page_i == data_space_pkg::EXT_LAST ||
                page_i == data_space_pkg::PROG_LAST)) ||
               (cross_dn && (page_i == data_space_pkg::EXT_FIRST ||
                page_i == data_space_pkg::PROG_FIRST));
    if (boundary) begin
      ptr_next_o[15] = 1'b0; // RL23
    end else if (cross_up) begin
      page_next_o = page_i + 10'h001; // RL18
      ptr_next_o[15] = 1'b1; // RL18
    end else if (cross_dn) begin
      page_next_o = page_i - 10'h001; // RL19
      ptr_next_o[15] = 1'b1; // RL19
    end
    // pre-modified access uses the corrected pointer
    ea_o = pre ? ptr_next_o : raw_ea; // RL17 RL18 RL19
  end
endmodule
`default_nettype wire

// ===== verilog/data_lane_unit.sv
// byte lane select, load merge and extension for read data
`timescale 1ns/1ps
`default_nettype none
module data_lane_unit (
  input wire logic [15:0] word_i,
  input wire logic addr0_i,
  input wire logic byte_i,
  input wire logic [1:0] ext_i,
  input wire logic [15:0] dest_old_i,
  output logic [15:0] value_o
);
  logic [7:0] sel;
  always_comb begin
    sel = addr0_i ? word_i[15:8] : word_i[7:0]; // RL5 RL7
    if (byte_i) begin
      value_o = {dest_old_i[15:8], sel}; // RL11
    end else begin
      value_o = word_i;
    end
    unique case (data_space_pkg::ext_e'(ext_i))
      data_space_pkg::EXT_SIGN: value_o = {{8{sel[7]}}, sel}; // RL12
      data_space_pkg::EXT_ZERO: value_o = {8'h00, sel}; // RL12
      data_space_pkg::EXT_NONE: begin
      end
      default: begin
      end
    endcase
  end
endmodule
`default_nettype wire

// ===== verification/sfr_model.sv
// peripheral register array on the far side of the block
`timescale 1ns/1ps
`default_nettype none
module sfr_model (
  input wire logic clk_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [1:0] wstrb_i,
  output logic [15:0] rdata_o,
  output logic hit_o
);
  logic [15:0] mem [0:2047];
  logic [15:0] noise_q = 16'h3c3c;
  // top quarter of the register region left empty
  assign hit_o = addr_i < 16'h0c00;
  // no stable value where nothing answers
  assign rdata_o = hit_o ? mem[addr_i[11:1]] : noise_q;
  always @(posedge clk_i) begin
    noise_q <= ~noise_q ^ 16'h0101;
    if (hit_o && wstrb_i[0]) mem[addr_i[11:1]][7:0] <= wdata_i[7:0];
    if (hit_o && wstrb_i[1]) mem[addr_i[11:1]][15:8] <= wdata_i[15:8];
  end
endmodule
`default_nettype wire

// ===== verification/data_space_addressing_checker.sv
// port assertions for data space addressing
`timescale 1ns/1ps
`default_nettype none
module data_space_addressing_checker (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic issue_i,
  input wire logic rd_en_i,
  input wire logic wr_en_i,
  input wire logic byte_i,
  input wire logic [2:0] rd_mode_i,
  input wire logic [15:0] rd_ptr_i,
  input wire logic [15:0] rd_direct_i,
  input wire logic [2:0] wr_mode_i,
  input wire logic [15:0] wr_direct_i,
  input wire logic [1:0] ext_i,
  input wire logic page_wr_rd_i,
  input wire logic sfr_hit_i,
  input wire logic [15:0] rd_value_o,
  input wire logic [15:0] rd_ptr_next_o,
  input wire logic [23:0] rd_ext_addr_o,
  input wire logic [9:0] read_page_select_o,
  input wire logic [1:0] sfr_wstrb_o,
  input wire logic done_o,
  input wire logic addr_err_trap_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic go;
  logic [8:0] pg_q;
  logic [14:0] dir_q;
  assign go = ce_i && issue_i;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pg_q <= '0;
      dir_q <= '0;
    end else if (go) begin
      pg_q <= read_page_select_o[8:0];
      dir_q <= rd_direct_i[14:0];
    end
  end
  a_odd_word_trap: assert property (go && rd_en_i && !byte_i &&
    rd_mode_i == 3'h0 && rd_direct_i[0] && !rd_direct_i[15]
    |=> ##1 addr_err_trap_o) else $error("odd word read without trap");
  a_misaligned_write_quiet: assert property (go && wr_en_i &&
    !byte_i && wr_mode_i == 3'h0 && wr_direct_i[0] |-> sfr_wstrb_o == 2'h0)
    else $error("misaligned write strobed");
  a_byte_lane_strobe: assert property (go && wr_en_i && byte_i &&
    wr_mode_i == 3'h0 && wr_direct_i < 16'h1000
    |-> sfr_wstrb_o == (wr_direct_i[0] ? 2'h2 : 2'h1))
    else $error("byte write lane wrong");
  a_post_inc_step: assert property (go && rd_en_i &&
    rd_mode_i == 3'h3 && !rd_ptr_i[15] |=> rd_ptr_next_o ==
    $past(rd_ptr_i) + ($past(byte_i) ? 16'h1 : 16'h2))
    else $error("post increment step wrong");
  a_page_concat: assert property (go && rd_en_i && !page_wr_rd_i &&
    rd_mode_i == 3'h0 && rd_direct_i[15] && read_page_select_o != 10'h0
    |=> rd_ext_addr_o == {pg_q, dir_q}) else $error("extended address wrong");
  a_unmapped_zero: assert property (go && rd_en_i && !wr_en_i &&
    !byte_i && ext_i == 2'h0 && rd_mode_i == 3'h0 && !rd_direct_i[0] &&
    ((rd_direct_i < 16'h1000 && !sfr_hit_i) ||
    (rd_direct_i > 16'h4fff && !rd_direct_i[15]))
    |=> rd_value_o == 16'h0) else $error("unmapped read not zero");
  a_trap_after_done: assert property (addr_err_trap_o |->
    $past(done_o)) else $error("trap without completed access");
  a_base_no_trap: assert property (go && rd_en_i && !wr_en_i &&
    rd_mode_i == 3'h0 && !rd_direct_i[15] && (byte_i || !rd_direct_i[0])
    |=> ##1 !addr_err_trap_o) else $error("base access trapped");
  c_dual_access: cover property (go && rd_en_i && wr_en_i);
  c_trap_seen: cover property (addr_err_trap_o);
  c_paged_post_inc: cover property (go && rd_mode_i == 3'h3 && rd_ptr_i[15]);
endmodule
`default_nettype wire

// ===== verification/data_space_addressing_bench.sv
// self-checking bench for data space addressing
`timescale 1ns/1ps
`default_nettype none
module data_space_addressing_bench;
  logic clk_i = 0, sys_rst_i = 1, issue_i = 0, rd_en_i = 0, wr_en_i = 0;
  logic byte_i = 0, page_wr_rd_i = 0, page_wr_wr_i = 0, tr_q = 0;
  logic sfr_hit_i, done_o, addr_err_trap_o;
  logic [2:0] rd_mode_i = 0, wr_mode_i = 0;
  logic [15:0] rd_ptr_i = 0, rd_direct_i = 0, wr_direct_i = 0;
  logic [15:0] wr_ptr_i = 0, wr_data_i = 0, dest_old_i = 16'h7700;
  logic [15:0] sfr_rdata_i, rd_value_o, rd_ptr_next_o, wr_ptr_next_o;
  logic [15:0] sfr_addr_o, sfr_wdata_o, s, a, n, w, v, d;
  logic [1:0] ext_i = 0, sfr_wstrb_o;
  logic [9:0] page_wdata_i = 0, read_page_select_o, write_page_select_o;
  logic [23:0] rd_ext_addr_o, wr_ext_addr_o;
  logic [34:0] e;
  logic [34:0] expq[$];
  int n_fail = 0, samples_checked = 0;
  always #25 clk_i = ~clk_i;
  data_space_addressing data_space_addressing_inst (.clk_i, .sys_rst_i,
    .ce_i(1'b1), .issue_i, .rd_en_i, .rd_mode_i, .rd_ptr_i, .rd_direct_i,
    .wr_en_i, .wr_mode_i, .wr_ptr_i, .wr_direct_i, .wr_data_i, .byte_i,
    .ext_i, .dest_old_i, .page_wr_rd_i, .page_wr_wr_i, .page_wdata_i,
    .sfr_rdata_i, .sfr_hit_i, .rd_value_o, .rd_ptr_next_o, .wr_ptr_next_o,
    .rd_ext_addr_o, .wr_ext_addr_o, .read_page_select_o,
    .write_page_select_o, .sfr_addr_o, .sfr_wdata_o, .sfr_wstrb_o, .done_o,
    .addr_err_trap_o);
  sfr_model sfr_model_inst (.clk_i, .addr_i(sfr_addr_o),
    .wdata_i(sfr_wdata_o), .wstrb_i(sfr_wstrb_o), .rdata_o(sfr_rdata_i),
    .hit_o(sfr_hit_i));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // e holds value check, pointer check, trap, value, next pointer
  task automatic op(input logic re, we, by, input logic [2:0] rm,
    input logic [15:0] rp, rdir, wa, wd, input logic [34:0] x);
    page_wr_rd_i = 0;
    page_wr_wr_i = 0;
    rd_en_i = re;
    wr_en_i = we;
    byte_i = by;
    rd_mode_i = rm;
    wr_mode_i = re ? 3'h0 : rm;
    rd_ptr_i = rp;
    rd_direct_i = rdir;
    wr_direct_i = wa;
    wr_data_i = wd;
    issue_i = 1;
    expq.push_back(x);
    @(negedge clk_i);
  endtask
  task automatic wr(input logic [15:0] wa, wd, input logic by, tr);
    op(0, 1, by, 3'h0, 16'h0, 16'h0, wa, wd, {2'b00, tr, 32'h0});
  endtask
  task automatic rdd(input logic [15:0] ra, rv, input logic by,
    input logic [1:0] ex, input logic tr);
    ext_i = ex;
    op(1, 0, by, 3'h0, 16'h0, ra, 16'h0, 16'h0, {2'b10, tr, rv, 16'h0});
  endtask
  task automatic pg(input logic r, wp, input logic [9:0] pv);
    issue_i = 0;
    page_wr_rd_i = r;
    page_wr_wr_i = wp;
    page_wdata_i = pv;
    @(negedge clk_i);
  endtask
  always @(negedge clk_i) begin
    if (!sys_rst_i) begin
      chk(addr_err_trap_o, tr_q);
      tr_q = 0;
      if (done_o === 1'b1) begin
        if (expq.size() == 0) chk(1, 0);
        else begin
          e = expq.pop_front();
          if (e[34]) chk(rd_value_o, e[31:16]);
          if (e[33]) chk(rd_ptr_next_o, e[15:0]);
          tr_q = e[32];
        end
      end
    end
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    stop_test;
  end
  initial begin
    void'($urandom(84));
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 0;
    chk(read_page_select_o, 10'h001);
    chk(write_page_select_o, 10'h001);
    wr(16'h0010, 16'h1234, 0, 0);
    wr(16'h0011, 16'h00ab, 1, 0);
    rdd(16'h0010, 16'hab34, 0, 0, 0);
    rdd(16'h0011, 16'h77ab, 1, 0, 0);
    wr(16'h1004, 16'h1234, 0, 0);
    wr(16'h1006, 16'h5678, 0, 0);
    wr(16'h1005, 16'hffff, 0, 1);
    rdd(16'h1004, 16'h1234, 0, 0, 0);
    rdd(16'h1006, 16'h5678, 0, 0, 0);
    op(1, 0, 0, 3'h0, 0, 16'h1005, 0, 0, {3'b001, 32'h0});
    wr(16'h1007, 16'hffff, 0, 1);
    wr(16'h1008, 16'h00f0, 1, 0);
    rdd(16'h1008, 16'hfff0, 1, 2'h1, 0);
    rdd(16'h1008, 16'h00f0, 1, 2'h2, 0);
    rdd(16'h5000, 16'h0, 0, 0, 0);
    rdd(16'h7ffe, 16'h0, 0, 0, 0);
    rdd(16'h0c00, 16'h0, 0, 0, 0);
    op(1, 0, 0, 3'h1, 0, 16'hf006, 0, 0, {3'b100, 16'h5678, 16'h0});
    for (int i = 0; i < 8; i++) begin
      a = 16'h3000 + 16'($urandom % 4096) * 16'h2;
      d = 16'($urandom);
      wr(a, d, 0, 0);
      rdd(a, d, 0, 0, 0);
    end
    for (int i = 0; i < 3; i++) begin
      a = 16'h2000 + 16'(i * 2);
      wr(a, a, 0, 0);
    end
    for (int m = 2; m < 7; m++) begin
      for (int b = 0; b < 2; b++) begin
        s = b[0] ? 16'h1 : 16'h2;
        a = (m == 5) ? 16'h2002 + s : (m == 6) ? 16'h2002 - s : 16'h2002;
        n = (m == 2) ? 16'h2002 :
            (m == 3 || m == 5) ? 16'h2002 + s : 16'h2002 - s;
        w = {a[15:1], 1'b0};
        v = b[0] ? {8'h77, a[0] ? w[15:8] : w[7:0]} : w;
        op(1, 0, b[0], m[2:0], 16'h2002, 0, 0, 0, {3'b110, v, n});
      end
    end
    pg(1, 0, 10'h005);
    rdd(16'h8000, 16'h0, 0, 0, 0);
    op(1, 0, 0, 3'h3, 16'hfffe, 0, 0, 0, {3'b110, 16'h0, 16'h8000});
    chk(read_page_select_o, 10'h006);
    op(1, 0, 0, 3'h4, 16'h8000, 0, 0, 0, {3'b010, 16'h0, 16'hfffe});
    chk(read_page_select_o, 10'h005);
    op(1, 0, 0, 3'h7, 16'hfffe, 16'h0002, 0, 0, {3'b000, 32'h0});
    chk(rd_ext_addr_o, {9'h005, 15'h0002});
    chk(read_page_select_o, 10'h005);
    pg(1, 0, 10'h1ff);
    op(1, 0, 0, 3'h3, 16'hfffe, 0, 0, 0, {3'b010, 16'h0, 16'h0000});
    chk(read_page_select_o, 10'h1ff);
    pg(1, 0, 10'h2ff);
    op(1, 0, 0, 3'h3, 16'hfffe, 0, 0, 0, {3'b010, 16'h0, 16'h8000});
    chk(read_page_select_o, 10'h300);
    op(1, 0, 0, 3'h5, 16'hfffe, 0, 0, 0, {3'b010, 16'h0, 16'h8000});
    chk(read_page_select_o, 10'h301);
    chk(rd_ext_addr_o, {9'h101, 15'h0000});
    pg(1, 0, 10'h000);
    op(1, 0, 0, 3'h0, 0, 16'h8000, 0, 0, {3'b001, 32'h0});
    rdd(16'h1006, 16'h5678, 0, 0, 0);
    pg(1, 0, 10'h201);
    pg(0, 1, 10'h003);
    op(1, 1, 0, 3'h0, 0, 16'h8010, 16'h8020, 16'h4321, {3'b000, 32'h0});
    chk(rd_ext_addr_o, {9'h001, 15'h0010});
    chk(wr_ext_addr_o, {9'h003, 15'h0020});
    pg(0, 1, 10'h200);
    wr(16'h8000, 16'h0001, 0, 1);
    pg(0, 0, 10'h000);
    repeat (3) @(negedge clk_i);
    stop_test;
  end
endmodule
bind data_space_addressing data_space_addressing_checker
  data_space_addressing_checker_inst (.clk_i, .sys_rst_i, .ce_i, .issue_i,
  .rd_en_i, .wr_en_i, .byte_i, .rd_mode_i, .rd_ptr_i, .rd_direct_i,
  .wr_mode_i, .wr_direct_i, .ext_i, .page_wr_rd_i, .sfr_hit_i, .rd_value_o,
  .rd_ptr_next_o, .rd_ext_addr_o, .read_page_select_o, .sfr_wstrb_o,
  .done_o, .addr_err_trap_o);
`default_nettype wire
